// ---- design/adcf_defs.vh ----
// constants for the converter sample fifo control block
`ifndef ADCF_DEFS_VH
`define ADCF_DEFS_VH

// ---------------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------------
`define ADCF_CTRL_ADDR      8'h3a
`define ADCF_CTRL_RESET     24'h040200
`define ADCF_CTRL_WR_MASK   24'h0fffff

// ---------------------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------------------
`define ADCF_ADD_STATUS_BIT 19
`define ADCF_ADD_HEADER_BIT 18
`define ADCF_MODE_HI        17
`define ADCF_MODE_LO        16
`define ADCF_WM_HI          7
`define ADCF_WM_LO          0

// ---------------------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------------------
`define ADCF_MODE_OFF       2'h0
`define ADCF_MODE_WM        2'h1

// ---------------------------------------------------------------------------
// fifo geometry and status word layout
// ---------------------------------------------------------------------------
`define ADCF_DEPTH          256
`define ADCF_CNT_W          9
`define ADCF_DATA_W         24
`define ADCF_HDR_W          8
`define ADCF_WORD_W         32
`define ADCF_ST_EMPTY       0
`define ADCF_ST_WM          1
`define ADCF_ST_OVERRUN     2
`define ADCF_ST_FULL        3

// ---------------------------------------------------------------------------
// readback word kinds
// ---------------------------------------------------------------------------
`define ADCF_KIND_STATUS    2'h1
`define ADCF_KIND_HEADER    2'h2
`define ADCF_KIND_DATA      2'h3

`endif

// ---- design/adcf_fifo.v ----
// synchronous sample fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module adcf_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_reset_n,
  input  wire             i_clear,
  // fill side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // drain side
  output wire             o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready,
  // fill level
  output wire [AW:0]      o_count
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  // a full fifo still accepts a push in the cycle it is popped
  assign o_out_valid = (count_r != {(AW+1){1'b0}});
  assign o_in_ready  = (count_r != DEPTH[AW:0]) || i_out_ready;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr_r];
  assign o_count     = count_r;

  always @(posedge i_mclk)
  begin
    if (push)
      mem[wr_ptr_r] <= i_in_data;
  end

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else if (i_clear)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- design/adcf_ctrl.v ----
// converter sample fifo control: modes, overrun, readback stream shaping
`timescale 1ns/1ps
`default_nettype none
`include "adcf_defs.vh"

module adcf_ctrl (
  // clock and reset
  input  wire                      i_mclk,
  input  wire                      i_reset_n,
  // register port from the serial interface
  input  wire                      i_reg_wr,
  input  wire                      i_reg_rd,
  input  wire [7:0]                i_reg_addr,
  input  wire [23:0]               i_reg_wdata,
  output wire [23:0]               o_reg_rdata,
  // conversion results from the filter
  input  wire                      i_conv_valid,
  input  wire [`ADCF_DATA_W-1:0]   i_conv_data,
  input  wire [`ADCF_HDR_W-1:0]    i_conv_hdr,
  // plain data register path
  output wire [`ADCF_DATA_W-1:0]   o_data_reg,
  output wire                      o_data_new,
  // fifo read command and stream
  input  wire                      i_rd_start,
  input  wire                      i_rd_ready,
  output wire                      o_rd_valid,
  output wire [`ADCF_DATA_W-1:0]   o_rd_word,
  output wire [1:0]                o_rd_kind,
  output wire                      o_rd_busy,
  // fifo status
  output wire [7:0]                o_fifo_status,
  output wire [`ADCF_CNT_W-1:0]    o_fifo_count
);

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  // watermark field to a sample count
  function [`ADCF_CNT_W-1:0] wm_level;
    input [7:0] wm;
    begin
      if (wm == 8'h00)
        wm_level = 9'h100;
      else
        wm_level = {1'b0, wm};
    end
  endfunction

  localparam S_IDLE = 2'h0;
  localparam S_STAT = 2'h1;
  localparam S_HDR  = 2'h2;
  localparam S_DATA = 2'h3;

  // -------------------------------------------------------------------------
  // control register
  // -------------------------------------------------------------------------
  reg  [23:0] ctrl_r;
  reg  [23:0] reg_rdata_r;
  wire [1:0]  mode;
  wire        add_status;
  wire        add_header;
  wire [`ADCF_CNT_W-1:0] wm_n;

  assign mode       = ctrl_r[`ADCF_MODE_HI:`ADCF_MODE_LO];
  assign add_status = ctrl_r[`ADCF_ADD_STATUS_BIT];
  assign add_header = ctrl_r[`ADCF_ADD_HEADER_BIT];
  assign wm_n       = wm_level(ctrl_r[`ADCF_WM_HI:`ADCF_WM_LO]);

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_r      <= `ADCF_CTRL_RESET;
      reg_rdata_r <= 24'h000000;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == `ADCF_CTRL_ADDR)
        ctrl_r <= i_reg_wdata & `ADCF_CTRL_WR_MASK;
      if (i_reg_rd)
        reg_rdata_r <= (i_reg_addr == `ADCF_CTRL_ADDR) ? ctrl_r : 24'h000000;
    end
  end

  // -------------------------------------------------------------------------
  // fifo and write policy
  // -------------------------------------------------------------------------
  wire                   fifo_out_valid;
  wire [`ADCF_WORD_W-1:0] fifo_out_data;
  wire [`ADCF_CNT_W-1:0] count;
  wire                   fifo_off;
  wire                   streaming;
  wire                   full_total;
  wire                   wm_reached;
  reg                    wm_lock_r;
  reg                    overrun_r;
  reg                    push;
  reg                    drop;
  reg                    rd_pop;
  wire                   fifo_pop;

  assign fifo_off   = (mode == `ADCF_MODE_OFF);
  assign streaming  = mode[1];
  assign full_total = (count == 9'h100);
  assign wm_reached = (count >= wm_n);
  assign fifo_pop   = rd_pop || drop;

  // decide whether a new conversion is stored, dropped, or displaces one
  always @*
  begin
    push = 1'b0;
    drop = 1'b0;
    if (i_conv_valid && !fifo_off)
    begin
      if (streaming)
      begin
        push = 1'b1;
        drop = full_total && !rd_pop;
      end
      else
        // below the watermark the fifo cannot be full, so no ready term
        push = !wm_lock_r && !wm_reached;
    end
  end

  adcf_fifo #(
    .WIDTH (`ADCF_WORD_W),
    .DEPTH (`ADCF_DEPTH),
    .AW    (8)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_reset_n   (i_reset_n),
    .i_clear     (fifo_off),
    .i_in_valid  (push),
    .i_in_data   ({i_conv_hdr, i_conv_data}),
    .o_in_ready  (),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_pop),
    .o_count     (count)
  );

  // -------------------------------------------------------------------------
  // readback stream
  // -------------------------------------------------------------------------
  reg  [1:0]              state_r;
  reg                     rd_valid_r;
  reg  [`ADCF_DATA_W-1:0] rd_word_r;
  reg  [1:0]              rd_kind_r;
  wire                    load;
  wire                    status_taken;
  wire [7:0]              status;

  assign load   = !rd_valid_r || i_rd_ready;
  assign status = {4'h0, full_total, overrun_r, wm_reached,
                   (count == 9'h000)};
  assign status_taken = load && (state_r == S_STAT);

  // reading a data word frees its entry
  always @*
  begin
    rd_pop = load && (state_r == S_DATA) && fifo_out_valid;
  end

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_r    <= S_IDLE;
      rd_valid_r <= 1'b0;
      rd_word_r  <= 24'h000000;
      rd_kind_r  <= 2'h0;
    end
    else if (fifo_off)
    begin
      state_r    <= S_IDLE;
      rd_valid_r <= 1'b0;
    end
    else if (state_r == S_IDLE)
    begin
      if (load)
        rd_valid_r <= 1'b0;
      if (i_rd_start)
      begin
        if (add_status)
          state_r <= S_STAT;
        else if (add_header)
          state_r <= S_HDR;
        else
          state_r <= S_DATA;
      end
    end
    else if (load)
    begin
      case (state_r)
        S_STAT:
        begin
          rd_valid_r <= 1'b1;
          rd_word_r  <= {16'h0000, status};
          rd_kind_r  <= `ADCF_KIND_STATUS;
          state_r    <= add_header ? S_HDR : S_DATA;
        end
        S_HDR:
        begin
          rd_valid_r <= fifo_out_valid;
          rd_word_r  <= {16'h0000,
                         fifo_out_data[`ADCF_WORD_W-1:`ADCF_DATA_W]};
          rd_kind_r  <= `ADCF_KIND_HEADER;
          state_r    <= fifo_out_valid ? S_DATA : S_IDLE;
        end
        S_DATA:
        begin
          rd_valid_r <= fifo_out_valid;
          rd_word_r  <= fifo_out_data[`ADCF_DATA_W-1:0];
          rd_kind_r  <= `ADCF_KIND_DATA;
          if (!fifo_out_valid)
            state_r <= S_IDLE;
          else
            state_r <= add_header ? S_HDR : S_DATA;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // watermark lock and overrun flag
  // -------------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wm_lock_r <= 1'b0;
      overrun_r <= 1'b0;
    end
    else if (fifo_off)
    begin
      wm_lock_r <= 1'b0;
      overrun_r <= 1'b0;
    end
    else
    begin
      // held until the stored block is drained completely
      if (mode == `ADCF_MODE_WM && wm_reached)
        wm_lock_r <= 1'b1;
      else if (count == 9'h000)
        wm_lock_r <= 1'b0;
      // a new drop wins over the clear by the status readout
      if (i_conv_valid && !streaming && !push)
        overrun_r <= 1'b1;
      else if (drop)
        overrun_r <= 1'b1;
      else if (status_taken)
        overrun_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // plain data register and status outputs
  // -------------------------------------------------------------------------
  reg [`ADCF_DATA_W-1:0] data_reg_r;
  reg                    data_new_r;
  reg [7:0]              status_r;
  reg [`ADCF_CNT_W-1:0]  count_r;
  reg                    busy_r;

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      data_reg_r <= 24'h000000;
      data_new_r <= 1'b0;
      status_r   <= 8'h00;
      count_r    <= 9'h000;
      busy_r     <= 1'b0;
    end
    else
    begin
      data_new_r <= i_conv_valid && fifo_off;
      if (i_conv_valid && fifo_off)
        data_reg_r <= i_conv_data;
      status_r <= status;
      count_r  <= count;
      busy_r   <= (state_r != S_IDLE) || (i_rd_start && !fifo_off);
    end
  end

  assign o_reg_rdata   = reg_rdata_r;
  assign o_data_reg    = data_reg_r;
  assign o_data_new    = data_new_r;
  assign o_rd_valid    = rd_valid_r;
  assign o_rd_word     = rd_word_r;
  assign o_rd_kind     = rd_kind_r;
  assign o_rd_busy     = busy_r;
  assign o_fifo_status = status_r;
  assign o_fifo_count  = count_r;

endmodule
`default_nettype wire

// ---- verif/adcf_ctrl_sva.sv ----
// assertion checker for the sample fifo control block
`timescale 1ns/1ps
`default_nettype none
`include "adcf_defs.vh"
module adcf_ctrl_chk (
  // watched ports
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic [23:0] o_reg_rdata,
  input wire logic        i_conv_valid,
  input wire logic        o_data_new,
  input wire logic        i_rd_start,
  input wire logic        i_rd_ready,
  input wire logic        o_rd_valid,
  input wire logic [1:0]  o_rd_kind,
  input wire logic        o_rd_busy,
  input wire logic [7:0]  o_fifo_status,
  input wire logic [8:0]  o_fifo_count
);
  logic [23:0] ctrl_r;
  logic [1:0]  up_r;
  logic [1:0]  st_cnt_r;
  logic [8:0]  wm_n;
  logic        go;
  assign wm_n = (ctrl_r[7:0] == 8'h00) ? 9'h100 : {1'b0, ctrl_r[7:0]};
  assign go   = i_rd_start && !o_rd_busy && (ctrl_r[17:16] != 2'h0);
  // ---------------------------------------------------------------
  // shadow of the control register and status word counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_r   <= `ADCF_CTRL_RESET;
      up_r     <= 2'h0;
      st_cnt_r <= 2'h0;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == `ADCF_CTRL_ADDR)
        ctrl_r <= i_reg_wdata & `ADCF_CTRL_WR_MASK;
      if (up_r != 2'h3)
        up_r <= up_r + 2'h1;
      if (!o_rd_busy)
        st_cnt_r <= 2'h0;
      else if (o_rd_valid && o_rd_kind == `ADCF_KIND_STATUS && i_rd_ready
               && st_cnt_r != 2'h3)
        st_cnt_r <= st_cnt_r + 2'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence s_hdr_taken;
    o_rd_valid && o_rd_kind == `ADCF_KIND_HEADER && i_rd_ready;
  endsequence
  sequence s_data_next;
    o_rd_valid && o_rd_kind == `ADCF_KIND_DATA;
  endsequence
  a_unmapped_read: assert property (i_reg_rd && i_reg_addr != 8'h3a |=>
    o_reg_rdata == 24'h000000) else $error("unmapped read not zero");
  a_ctrl_read_back: assert property (i_reg_rd && !i_reg_wr &&
    i_reg_addr == 8'h3a |=> o_reg_rdata == ctrl_r) else $error("ctrl read");
  a_status_first: assert property (go && ctrl_r[19] |-> ##2
    (o_rd_valid && o_rd_kind == `ADCF_KIND_STATUS)) else $error("no status");
  a_status_once: assert property (st_cnt_r <= 2'h1)
    else $error("status word repeated");
  a_header_first: assert property (go && !ctrl_r[19] && ctrl_r[18] &&
    o_fifo_count != 9'h000 |-> ##2 (o_rd_valid && o_rd_kind ==
    `ADCF_KIND_HEADER)) else $error("no leading header");
  a_header_data: assert property (s_hdr_taken |=> s_data_next)
    else $error("header not followed by data");
  a_off_new_data: assert property (i_conv_valid && ctrl_r[17:16] == 2'h0
    |-> ##[1:2] o_data_new) else $error("data register not updated");
  a_wm_bound: assert property (ctrl_r[17:16] == 2'h1 && up_r == 2'h3
    |-> o_fifo_count <= wm_n) else $error("watermark count exceeded");
  a_depth_bound: assert property (o_fifo_count <= 9'h100)
    else $error("count above depth");
  a_wm_flag: assert property (up_r == 2'h3 && ctrl_r[17:16] != 2'h0 &&
    o_fifo_count >= wm_n && $stable(o_fifo_count) |->
    o_fifo_status[`ADCF_ST_WM]) else $error("watermark flag low");
  a_wm_overrun: assert property (ctrl_r[17:16] == 2'h1 && !o_rd_busy &&
    o_fifo_count >= wm_n && i_conv_valid |-> ##[1:3]
    o_fifo_status[`ADCF_ST_OVERRUN]) else $error("no watermark overrun");
  a_stream_overrun: assert property (ctrl_r[17] && !o_rd_busy &&
    o_fifo_count == 9'h100 && i_conv_valid |-> ##[1:3]
    o_fifo_status[`ADCF_ST_OVERRUN]) else $error("no stream overrun");
endmodule
bind adcf_ctrl adcf_ctrl_chk adcf_ctrl_chk_inst (.i_mclk, .i_reset_n,
  .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .i_conv_valid, .o_data_new, .i_rd_start, .i_rd_ready, .o_rd_valid,
  .o_rd_kind, .o_rd_busy, .o_fifo_status, .o_fifo_count);
`default_nettype wire

// ---- verif/adcf_host.sv ----
// host reader model taking the readback stream, optionally stalling
`timescale 1ns/1ps
`default_nettype none
module adcf_host (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // stall control and stream
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic [23:0] i_word,
  input  wire logic [1:0]  i_kind,
  output var  logic        o_ready
);
  logic [25:0] got_q[$];
  logic [1:0]  ph_r;
  // when slow, ready is high one cycle in four
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_ready <= 1'b0;
      ph_r    <= 2'h0;
    end
    else
    begin
      ph_r    <= ph_r + 2'h1;
      o_ready <= !i_slow || (ph_r == 2'h0);
      if (i_valid && o_ready)
        got_q.push_back({i_kind, i_word});
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking testbench for the sample fifo control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_mclk, i_reset_n, i_reg_wr, i_reg_rd, i_conv_valid;
  logic        i_rd_start, i_rd_ready, slow, o_data_new, o_rd_valid;
  logic        o_rd_busy;
  logic [7:0]  i_reg_addr, i_conv_hdr, o_fifo_status;
  logic [23:0] i_reg_wdata, i_conv_data, o_reg_rdata, o_data_reg;
  logic [23:0] o_rd_word, rv;
  logic [1:0]  o_rd_kind;
  logic [8:0]  o_fifo_count;
  int          error_cnt, total_checks, cyc, new_cnt;
  adcf_ctrl adcf_ctrl_inst (.i_mclk, .i_reset_n, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_conv_valid, .i_conv_data,
    .i_conv_hdr, .o_data_reg, .o_data_new, .i_rd_start, .i_rd_ready,
    .o_rd_valid, .o_rd_word, .o_rd_kind, .o_rd_busy, .o_fifo_status,
    .o_fifo_count);
  adcf_host adcf_host_inst (.i_mclk, .i_reset_n, .i_slow(slow),
    .i_valid(o_rd_valid), .i_word(o_rd_word), .i_kind(o_rd_kind),
    .o_ready(i_rd_ready));
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  // plain data register update pulses, sampled where they are settled
  always @(negedge i_mclk)
  begin
    if (o_data_new === 1'b1)
      new_cnt++;
  end
  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [23:0] d);
    @(negedge i_mclk);
    i_reg_wr    = 1'b1;
    i_reg_addr  = a;
    i_reg_wdata = d;
    @(negedge i_mclk);
    i_reg_wr    = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge i_mclk);
    i_reg_rd   = 1'b1;
    i_reg_addr = a;
    @(negedge i_mclk);
    i_reg_rd   = 1'b0;
    @(negedge i_mclk);
    rv = o_reg_rdata;
  endtask
  task automatic conv(int n, logic [23:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(negedge i_mclk);
      i_conv_valid = 1'b1;
      i_conv_data  = base + i[23:0];
      i_conv_hdr   = i[7:0];
    end
    @(negedge i_mclk);
    i_conv_valid = 1'b0;
    repeat (3) @(negedge i_mclk);
  endtask
  task automatic readout;
    adcf_host_inst.got_q.delete();
    @(negedge i_mclk);
    i_rd_start = 1'b1;
    @(negedge i_mclk);
    i_rd_start = 1'b0;
    repeat (2) @(negedge i_mclk);
    for (int k = 0; k < 3000 && o_rd_busy; k++)
      @(negedge i_mclk);
    chk("rd_busy", o_rd_busy, 0);
    repeat (3) @(negedge i_mclk);
  endtask
  task automatic t_regs;
    rd(8'h3a);
    chk("ctrl_reset", rv, 24'h040200);
    wr(8'h3a, 24'hffffff);
    wr(8'h55, 24'h000000);
    rd(8'h3a);
    chk("ctrl_mask", rv, 24'h0fffff);
    rd(8'h55);
    chk("unmapped", rv, 24'h000000);
  endtask
  task automatic t_off;
    wr(8'h3a, 24'h040000);
    conv(1, 24'h00abcd);
    chk("data_reg", o_data_reg, 24'h00abcd);
    chk("data_new", new_cnt, 1);
    chk("off_count", o_fifo_count, 9'h000);
    readout;
    chk("off_stream", adcf_host_inst.got_q.size(), 0);
  endtask
  task automatic t_wm;
    logic [25:0] q[$];
    wr(8'h3a, 24'h0d0004);
    slow = 1'b1;
    conv(6, 24'h000100);
    conv(1, 24'h000106);
    chk("wm_count", o_fifo_count, 9'h004);
    chk("wm_flags", o_fifo_status[2:1], 2'h3);
    readout;
    q = adcf_host_inst.got_q;
    chk("wm_words", q.size(), 9);
    chk("wm_status", q[0][25:24], 2'h1);
    chk("wm_st_word", q[0][2:1], 2'h3);
    for (int i = 0; i < 4; i++)
    begin
      chk("wm_hdr", {q[1+2*i][25:24], q[1+2*i][7:0]}, {2'h2, i[7:0]});
      chk("wm_data", q[2+2*i], {2'h3, 24'h000100 + i[23:0]});
    end
    chk("wm_empty", o_fifo_count, 9'h000);
    conv(1, 24'h000200);
    chk("wm_resume", o_fifo_count, 9'h001);
    slow = 1'b0;
    wr(8'h3a, 24'h040000);
  endtask
  task automatic t_stream(logic [1:0] m, logic h);
    logic [25:0] q[$];
    int          w;
    w = h ? 2 : 1;
    wr(8'h3a, {5'h00, h, m, 16'h0004});
    conv(257, 24'h000000);
    conv(1, 24'h000101);
    chk("st_count", o_fifo_count, 9'h100);
    chk("st_flags", {o_fifo_status[3], o_fifo_status[2]}, 2'h3);
    readout;
    q = adcf_host_inst.got_q;
    chk("st_words", q.size(), 256 * w);
    chk("st_oldest", q[w-1], {2'h3, 24'h000002});
    chk("st_newest", q[256*w-1], {2'h3, 24'h000101});
    if (h)
      chk("st_hdr", {q[0][25:24], q[0][7:0]}, {2'h2, 8'h02});
    wr(8'h3a, 24'h040000);
  endtask
  task automatic t_wm0;
    wr(8'h3a, 24'h010000);
    conv(257, 24'h000000);
    chk("wm0_count", o_fifo_count, 9'h100);
    chk("wm0_flags", o_fifo_status[2:1], 2'h3);
    wr(8'h3a, 24'h040000);
  endtask
  initial
  begin
    {i_reg_wr, i_reg_rd, i_conv_valid, i_rd_start, slow} = 5'h00;
    {i_reg_addr, i_conv_hdr, i_reg_wdata, i_conv_data} = 64'h0;
    {error_cnt, total_checks, cyc, new_cnt} = 128'h0;
    i_reset_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_mclk);
    t_regs();
    t_off();
    t_wm();
    t_stream(2'h2, 1'b0);
    t_stream(2'h3, 1'b1);
    t_wm0();
    finish_test();
  end
endmodule
`default_nettype wire
